// ### logic/fws_pkg.sv
package fws_pkg;
  // Bus widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PULSE_MIN_NS = 60;
  localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSPEND_LATENCY_US = 10;
  localparam int SUSPEND_LATENCY_CYC = SUSPEND_LATENCY_US * 1000 / CLK_PERIOD_NS;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_MIN_NS = 50;
  localparam int RESET_RECOVERY_CYC =
    (RESET_RECOVERY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // Guard prefix addresses and data
  localparam logic [ADDR_W-1:0] GUARD_ADDR_A = 21'h000555;
  localparam logic [ADDR_W-1:0] GUARD_ADDR_B = 21'h0002AA;
  localparam logic [DATA_W-1:0] GUARD_DATA_A = 16'h00AA;
  localparam logic [DATA_W-1:0] GUARD_DATA_B = 16'h0055;
  // Command codes
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0050;
  localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_ID_ENTRY = 16'h0090;
  // Status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int SUSP_TOGGLE_BIT = 2;
  // Bank select field
  localparam int BANK_HI = 20;
  localparam int BANK_LO = 18;
  // User operation codes
  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
    OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_ID_ENTRY
  } fws_op_t;
  // Completion results
  typedef enum logic [1:0] {RES_OK, RES_FAIL, RES_ABORT} fws_res_t;
endpackage : fws_pkg

// ### logic/fws_bus_cycle.sv
`timescale 1ns/100ps
`default_nettype none
// One bus cycle on the flash pins: a write strobe or an output-gated read
module fws_bus_cycle (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Request
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [fws_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fws_pkg::DATA_W-1:0] wdata_i,
  output logic done_o,
  output logic [fws_pkg::DATA_W-1:0] rdata_o,
  // Flash pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [fws_pkg::ADDR_W-1:0] addr_o,
  output logic [fws_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [fws_pkg::DATA_W-1:0] dq_i
);
  typedef enum logic [1:0] {BC_IDLE, BC_STROBE, BC_RECOVER} fws_bc_t;
  fws_bc_t state_ff;
  logic [fws_pkg::CNT_W-1:0] cnt_ff;
  logic wr_ff;

  // Strobe held low for two clocks so it is never a short glitch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= BC_IDLE;
      cnt_ff <= '0;
      wr_ff <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_n_o <= 1'b1;
      rdata_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_ff)
        BC_IDLE: begin
          if (start_i) begin
            addr_o <= addr_i;
            dq_o <= wdata_i;
            wr_ff <= write_i;
            dq_oe_n_o <= !write_i;
            ce_n_o <= 1'b0;
            we_n_o <= !write_i;
            oe_n_o <= write_i;
            cnt_ff <= fws_pkg::CNT_W'(fws_pkg::PULSE_CYC - 1);
            state_ff <= BC_STROBE;
          end
        end
        BC_STROBE: begin
          if (cnt_ff == '0) begin
            if (!wr_ff) begin
              rdata_o <= dq_i;
            end
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            ce_n_o <= 1'b1;
            state_ff <= BC_RECOVER;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        BC_RECOVER: begin
          dq_oe_n_o <= 1'b1;
          done_o <= 1'b1;
          state_ff <= BC_IDLE;
        end
        default: state_ff <= BC_IDLE;
      endcase
    end
  end
endmodule // fws_bus_cycle
`default_nettype wire

// ### logic/fws_host.sv
`timescale 1ns/100ps
`default_nettype none
module fws_host (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // User command port
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic [2:0] REQ_OP_I,
  input wire logic [fws_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [fws_pkg::DATA_W-1:0] REQ_DATA_I,
  input wire logic WIDE_I,
  input wire logic UNPROTECT_I,
  input wire logic FLASH_RESET_I,
  // User answer
  output logic RSP_VALID_O,
  output logic [1:0] RSP_RES_O,
  output logic [fws_pkg::DATA_W-1:0] RSP_DATA_O,
  output logic ERASE_SUSPENDED_O,
  output logic ERASE_LOST_O,
  // Flash pins
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O,
  output logic FL_BYTE_N_O,
  output logic FL_WP_N_O,
  output logic FL_RST_N_O,
  output logic [fws_pkg::ADDR_W-1:0] FL_ADDR_O,
  output logic [fws_pkg::DATA_W-1:0] FL_DQ_O,
  output logic FL_DQ_OE_N_O,
  input wire logic [fws_pkg::DATA_W-1:0] FL_DQ_I,
  input wire logic FL_READY_BUSY_N_I
);
  typedef enum logic [3:0] {
    S_IDLE, S_WRITE, S_WAIT_WR, S_POLL, S_WAIT_RD, S_CHECK, S_WAIT, S_RESET, S_RECOVER
  } fws_st_t;
  fws_st_t state_ff;
  fws_pkg::fws_op_t op_ff;
  logic [fws_pkg::ADDR_W-1:0] addr_ff;
  logic [fws_pkg::DATA_W-1:0] data_ff;
  logic [2:0] step_ff;
  logic [2:0] last_step_ff;
  logic [fws_pkg::DATA_W-1:0] prev_ff;
  logic have_prev_ff;
  logic [1:0] confirm_ff;
  logic [fws_pkg::CNT_W-1:0] wait_ff;
  logic susp_ff;
  logic lost_ff;
  logic erasing_ff;
  logic bc_start;
  logic bc_write;
  logic bc_done;
  logic [fws_pkg::ADDR_W-1:0] bc_addr;
  logic [fws_pkg::DATA_W-1:0] bc_wdata;
  logic [fws_pkg::DATA_W-1:0] bc_rdata;
  logic [fws_pkg::ADDR_W-1:0] bank_addr;
  logic [fws_pkg::DATA_W-1:0] rd_word;
  logic toggled;
  logic op_done;
  logic susp_ok;

  // Program prefix plus one; erase prefix plus three
  function automatic logic [2:0] last_step(input fws_pkg::fws_op_t op);
    case (op)
      fws_pkg::OP_PROGRAM: last_step = 3'd3;
      fws_pkg::OP_SECTOR_ERASE, fws_pkg::OP_BLOCK_ERASE,
      fws_pkg::OP_CHIP_ERASE: last_step = 3'd5;
      fws_pkg::OP_ID_ENTRY: last_step = 3'd2;
      default: last_step = 3'd0;                      // Suspend, resume: single cycle
    endcase
  endfunction

  // Guard cycle address, bank bits taken from the target
  always_comb begin
    bank_addr = fws_pkg::GUARD_ADDR_A;
    bank_addr[fws_pkg::BANK_HI:fws_pkg::BANK_LO] =
      addr_ff[fws_pkg::BANK_HI:fws_pkg::BANK_LO];
    bc_addr = addr_ff;
    bc_wdata = data_ff;
    if (state_ff == S_WRITE && step_ff != last_step_ff) begin
      case (step_ff)
        3'd0, 3'd3: begin
          bc_addr = bank_addr;
          bc_wdata = fws_pkg::GUARD_DATA_A;
        end
        3'd1, 3'd4: begin
          bc_addr = bank_addr;
          bc_addr[fws_pkg::BANK_LO-1:0] = fws_pkg::GUARD_ADDR_B[fws_pkg::BANK_LO-1:0];
          bc_wdata = fws_pkg::GUARD_DATA_B;
        end
        default: begin
          bc_addr = bank_addr;
          case (op_ff)
            fws_pkg::OP_PROGRAM: bc_wdata = fws_pkg::CMD_PROGRAM;
            fws_pkg::OP_ID_ENTRY: bc_wdata = fws_pkg::CMD_ID_ENTRY;
            default: bc_wdata = fws_pkg::CMD_ERASE_SETUP;
          endcase
        end
      endcase
    end else if (state_ff == S_WRITE) begin
      case (op_ff)
        fws_pkg::OP_SECTOR_ERASE: bc_wdata = fws_pkg::CMD_SECTOR_ERASE;
        fws_pkg::OP_BLOCK_ERASE: bc_wdata = fws_pkg::CMD_BLOCK_ERASE;
        fws_pkg::OP_CHIP_ERASE: begin
          bc_addr = bank_addr;
          bc_wdata = fws_pkg::CMD_CHIP_ERASE;
        end
        fws_pkg::OP_SUSPEND: bc_wdata = fws_pkg::CMD_SUSPEND;
        fws_pkg::OP_RESUME: bc_wdata = fws_pkg::CMD_RESUME;
        default: bc_wdata = data_ff;
      endcase
    end
  end

  assign bc_start = (state_ff == S_WRITE) || (state_ff == S_POLL);
  assign bc_write = (state_ff == S_WRITE);
  // Byte mode only the low lane counts
  assign rd_word = WIDE_I ? bc_rdata : {8'h00, bc_rdata[7:0]};
  assign toggled = (rd_word[fws_pkg::TOGGLE_BIT] != prev_ff[fws_pkg::TOGGLE_BIT]);
  // Poll bit rule differs by operation
  assign op_done = (op_ff == fws_pkg::OP_PROGRAM) ?
    (rd_word[fws_pkg::POLL_BIT] == data_ff[fws_pkg::POLL_BIT]) :
    rd_word[fws_pkg::POLL_BIT];
  // A running sector or block erase can only be paused from the polling loop
  assign susp_ok = (state_ff == S_CHECK) && erasing_ff && !susp_ff && !op_done
    && (op_ff inside {fws_pkg::OP_SECTOR_ERASE, fws_pkg::OP_BLOCK_ERASE, fws_pkg::OP_RESUME})
    && (fws_pkg::fws_op_t'(REQ_OP_I) == fws_pkg::OP_SUSPEND);
  assign REQ_READY_O = (state_ff == S_IDLE && FL_READY_BUSY_N_I) || susp_ok;

  fws_bus_cycle u_cycle (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .start_i(bc_start),
    .write_i(bc_write),
    .addr_i(bc_addr),
    .wdata_i(bc_wdata),
    .done_o(bc_done),
    .rdata_o(bc_rdata),
    .ce_n_o(FL_CE_N_O),
    .oe_n_o(FL_OE_N_O),
    .we_n_o(FL_WE_N_O),
    .addr_o(FL_ADDR_O),
    .dq_o(FL_DQ_O),
    .dq_oe_n_o(FL_DQ_OE_N_O),
    .dq_i(FL_DQ_I)
  );

  // Pin levels for width and protection
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FL_BYTE_N_O <= 1'b1;
      FL_WP_N_O <= 1'b0;
    end else if (state_ff == S_IDLE) begin
      FL_BYTE_N_O <= WIDE_I;
      FL_WP_N_O <= UNPROTECT_I;
    end
  end

  // Main sequencer
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_ff <= S_IDLE;
      op_ff <= fws_pkg::OP_READ;
      addr_ff <= '0;
      data_ff <= '0;
      step_ff <= '0;
      last_step_ff <= '0;
      prev_ff <= '0;
      have_prev_ff <= 1'b0;
      confirm_ff <= '0;
      wait_ff <= '0;
      susp_ff <= 1'b0;
      lost_ff <= 1'b0;
      erasing_ff <= 1'b0;
      FL_RST_N_O <= 1'b1;
      RSP_VALID_O <= 1'b0;
      RSP_RES_O <= fws_pkg::RES_OK;
      RSP_DATA_O <= '0;
    end else begin
      RSP_VALID_O <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (FLASH_RESET_I) begin
            FL_RST_N_O <= 1'b0;
            wait_ff <= fws_pkg::CNT_W'(fws_pkg::RESET_PULSE_CYC);
            lost_ff <= lost_ff | erasing_ff | susp_ff;
            erasing_ff <= 1'b0;
            susp_ff <= 1'b0;
            state_ff <= S_RESET;
          end else if (REQ_VALID_I && FL_READY_BUSY_N_I) begin
            op_ff <= fws_pkg::fws_op_t'(REQ_OP_I);
            addr_ff <= REQ_ADDR_I;
            data_ff <= REQ_DATA_I;
            step_ff <= '0;
            last_step_ff <= last_step(fws_pkg::fws_op_t'(REQ_OP_I));
            have_prev_ff <= 1'b0;
            confirm_ff <= '0;
            if (fws_pkg::fws_op_t'(REQ_OP_I) == fws_pkg::OP_READ) begin
              state_ff <= S_POLL;
            end else if (susp_ff && (fws_pkg::fws_op_t'(REQ_OP_I) == fws_pkg::OP_SECTOR_ERASE
                || fws_pkg::fws_op_t'(REQ_OP_I) == fws_pkg::OP_BLOCK_ERASE
                || fws_pkg::fws_op_t'(REQ_OP_I) == fws_pkg::OP_CHIP_ERASE
                || fws_pkg::fws_op_t'(REQ_OP_I) == fws_pkg::OP_SUSPEND)) begin
              RSP_VALID_O <= 1'b1;
              RSP_RES_O <= fws_pkg::RES_ABORT;
            end else begin
              state_ff <= S_WRITE;
            end
          end
        end
        S_WRITE: state_ff <= S_WAIT_WR;
        S_WAIT_WR: begin
          if (bc_done) begin
            if (step_ff != last_step_ff) begin
              step_ff <= step_ff + 3'd1;
              state_ff <= S_WRITE;
            end else begin
              case (op_ff)
                fws_pkg::OP_PROGRAM, fws_pkg::OP_SECTOR_ERASE, fws_pkg::OP_BLOCK_ERASE,
                fws_pkg::OP_CHIP_ERASE, fws_pkg::OP_RESUME: begin
                  erasing_ff <= (op_ff != fws_pkg::OP_PROGRAM) || erasing_ff;
                  if (op_ff == fws_pkg::OP_RESUME) begin
                    susp_ff <= 1'b0;
                  end
                  state_ff <= S_POLL;
                end
                fws_pkg::OP_SUSPEND: begin
                  susp_ff <= erasing_ff;
                  wait_ff <= fws_pkg::CNT_W'(fws_pkg::SUSPEND_LATENCY_CYC);
                  state_ff <= S_WAIT;
                end
                default: begin
                  RSP_VALID_O <= 1'b1;
                  RSP_RES_O <= fws_pkg::RES_OK;
                  state_ff <= S_IDLE;
                end
              endcase
            end
          end
        end
        S_POLL: state_ff <= S_WAIT_RD;               // Address in operating bank
        S_WAIT_RD: if (bc_done) state_ff <= S_CHECK;
        S_CHECK: begin
          RSP_DATA_O <= rd_word;
          prev_ff <= rd_word;
          have_prev_ff <= 1'b1;
          if (susp_ok && REQ_VALID_I) begin
            // The paused erase gets no answer of its own; resume answers for it
            op_ff <= fws_pkg::OP_SUSPEND;
            addr_ff <= REQ_ADDR_I;
            step_ff <= '0;
            last_step_ff <= '0;
            state_ff <= S_WRITE;
          end else if (op_ff == fws_pkg::OP_READ) begin
            RSP_VALID_O <= 1'b1;
            RSP_RES_O <= fws_pkg::RES_OK;
            state_ff <= S_IDLE;
          end else if (!have_prev_ff || toggled || !op_done) begin
            confirm_ff <= '0;                        // Still busy, poll again
            state_ff <= S_POLL;
          end else if (confirm_ff == 2'd2) begin
            // A program finished during a suspend leaves the paused erase pending
            erasing_ff <= erasing_ff && (op_ff == fws_pkg::OP_PROGRAM);
            RSP_VALID_O <= 1'b1;
            RSP_RES_O <= fws_pkg::RES_OK;
            state_ff <= S_IDLE;
          end else begin
            confirm_ff <= confirm_ff + 2'd1;
            state_ff <= S_POLL;
          end
        end
        S_WAIT: begin
          if (wait_ff == '0) begin
            RSP_VALID_O <= 1'b1;
            RSP_RES_O <= fws_pkg::RES_OK;
            state_ff <= S_IDLE;
          end else begin
            wait_ff <= wait_ff - 1'b1;
          end
        end
        S_RESET: begin
          if (wait_ff == '0) begin
            FL_RST_N_O <= 1'b1;
            wait_ff <= fws_pkg::CNT_W'(fws_pkg::RESET_RECOVERY_CYC);
            state_ff <= S_RECOVER;
          end else begin
            wait_ff <= wait_ff - 1'b1;
          end
        end
        S_RECOVER: begin
          if (wait_ff == '0) begin
            RSP_VALID_O <= 1'b1;
            RSP_RES_O <= fws_pkg::RES_ABORT;
            state_ff <= S_IDLE;
          end else begin
            wait_ff <= wait_ff - 1'b1;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Status to the user
  assign ERASE_SUSPENDED_O = susp_ff;
  assign ERASE_LOST_O = lost_ff;
endmodule // fws_host
`default_nettype wire

// ### verification/fws_host_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Pin protocol watcher for the flash host
module fws_host_properties (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // User side
  input wire logic REQ_VALID_I,
  input wire logic REQ_READY_O,
  input wire logic [2:0] REQ_OP_I,
  input wire logic WIDE_I,
  input wire logic UNPROTECT_I,
  input wire logic RSP_VALID_O,
  input wire logic [1:0] RSP_RES_O,
  input wire logic ERASE_SUSPENDED_O,
  // Flash pins
  input wire logic FL_CE_N_O,
  input wire logic FL_OE_N_O,
  input wire logic FL_WE_N_O,
  input wire logic FL_BYTE_N_O,
  input wire logic FL_WP_N_O,
  input wire logic FL_RST_N_O,
  input wire logic [fws_pkg::ADDR_W-1:0] FL_ADDR_O,
  input wire logic [fws_pkg::DATA_W-1:0] FL_DQ_O,
  input wire logic FL_DQ_OE_N_O,
  input wire logic FL_READY_BUSY_N_I
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  // Write strobe low two cycles, then high
  sequence s_we_pulse;
    !FL_WE_N_O [*2] ##1 FL_WE_N_O;
  endsequence
  // Refusal answer with no strobe on the pins
  sequence s_refuse;
    RSP_VALID_O && RSP_RES_O == 2'h2 && FL_WE_N_O;
  endsequence
  property p_wr_gate;
    !FL_WE_N_O |-> FL_OE_N_O && !FL_CE_N_O;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("strobe without select");
  property p_we_width;
    $fell(FL_WE_N_O) |-> s_we_pulse;
  endproperty
  a_we_width: assert property (p_we_width) else $error("strobe width wrong");
  property p_data_hold;
    $rose(FL_WE_N_O) |-> !FL_DQ_OE_N_O && $stable(FL_DQ_O) && $stable(FL_ADDR_O);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved at strobe");
  property p_read_free;
    !FL_OE_N_O |-> FL_DQ_OE_N_O;
  endproperty
  a_read_free: assert property (p_read_free) else $error("bus driven in read");
  property p_rst_pulse;
    $fell(FL_RST_N_O) |-> !FL_RST_N_O [*8];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
  property p_rst_quiet;
    !FL_RST_N_O |-> FL_CE_N_O && FL_WE_N_O;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("access during reset");
  property p_width;
    REQ_READY_O |=> FL_BYTE_N_O == $past(WIDE_I);
  endproperty
  a_width: assert property (p_width) else $error("width pin not following");
  property p_wp;
    REQ_READY_O |=> FL_WP_N_O == $past(UNPROTECT_I);
  endproperty
  a_wp: assert property (p_wp) else $error("protect pin not following");
  property p_busy_hold;
    !FL_READY_BUSY_N_I && REQ_OP_I != 3'h5 |-> !REQ_READY_O;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("ready while busy");
  property p_rsp_pulse;
    RSP_VALID_O |=> !RSP_VALID_O;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");
  property p_refuse;
    ERASE_SUSPENDED_O && REQ_VALID_I && REQ_READY_O && REQ_OP_I inside {3'h2, 3'h3, 3'h5}
      |=> s_refuse;
  endproperty
  a_refuse: assert property (p_refuse) else $error("erase not refused");
endmodule // fws_host_properties
bind fws_host fws_host_properties u_fws_host_properties (.*);
`default_nettype wire

// ### verification/fws_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural eight-bank flash seen from its pins
module fws_flash_model #(
  parameter int PROG_CYC = 30,
  parameter int ERASE_CYC = 300,
  parameter int PROT_END = 21'h002000
) (
  // Timing clock only
  input wire logic clk_i,
  // Bus control
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic byte_n_i,
  input wire logic wp_n_i,
  input wire logic rst_n_i,
  // Address and data
  input wire logic [fws_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fws_pkg::DATA_W-1:0] dq_i,
  output logic [fws_pkg::DATA_W-1:0] dq_o,
  // Open-drain ready line, low enable pulls low
  output logic rb_oe_n_o
);
  logic [15:0] mem[int];
  logic [15:0] wd = 16'h0000;
  logic [15:0] rd = 16'h0000;
  logic [20:0] tgt = 21'h000000;
  logic [20:0] etgt = 21'h000000;
  int step = 0;
  int busy = 0;
  int ebusy = 0;
  bit susp, tog, stog, wsel;
  // Erased words read as all ones
  function automatic logic [15:0] rf(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  // Erase unprotected words matching target under mask
  task automatic wipe(input int msk);
    foreach (mem[k]) begin
      if ((k & msk) == (etgt & msk) && (wp_n_i || k >= PROT_END)) mem[k] = 16'hFFFF;
    end
  endtask
  // Select level caught as the strobe falls, steady for the whole pulse
  always @(negedge we_n_i) wsel = !ce_n_i && oe_n_i;
  // Command decoder on the rising write strobe
  always @(posedge we_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step = 0;
      busy = 0;
      ebusy = 0;
      susp = 0;
    end else if (wsel && busy == 0) begin
      if (ebusy > 0 && !susp) begin
        if (dq_i[7:0] == 8'hB0) susp = 1;
      end else if (susp && step == 0 && dq_i[7:0] == 8'h30) susp = 0;
      else if (step == 6) begin
        if (wp_n_i || addr_i >= PROT_END) mem[addr_i] = rf(addr_i) & dq_i;
        wd = dq_i;
        tgt = addr_i;
        busy = PROG_CYC;
        step = 0;
      end else if (step == 5) begin
        etgt = addr_i;
        ebusy = ERASE_CYC;
        step = 0;
        case (dq_i[7:0])
          8'h50: wipe(21'h1FF800);
          8'h30: wipe(21'h1F8000);
          8'h10: if (wp_n_i) wipe(0); else ebusy = 0;
          default: ebusy = 0;
        endcase
      end else if (addr_i[10:0] == 11'h555 && dq_i[7:0] == 8'hAA && step inside {0, 3}) step++;
      else if (addr_i[10:0] == 11'h2AA && dq_i[7:0] == 8'h55 && step inside {1, 4}) step++;
      else if (step == 2 && dq_i[7:0] == 8'hA0) step = 6;
      else if (step == 2 && dq_i[7:0] == 8'h80) step = 3;
      else step = 0;
    end
  end
  // Internal operation timers, the erase timer frozen while suspended
  always @(posedge clk_i) begin
    if (busy > 0) busy <= busy - 1;
    if (ebusy > 0 && !susp) ebusy <= ebusy - 1;
  end
  // Array or status value taken as the output gate falls
  always @(negedge oe_n_i) begin
    if (!ce_n_i && rst_n_i) begin
      rd = rf(addr_i);
      if (busy > 0 && addr_i[20:18] == tgt[20:18]) begin
        tog = !tog;
        rd[7] = ~wd[7];
        rd[6] = tog;
      end else if (ebusy > 0 && addr_i[20:18] == etgt[20:18]) begin
        tog = !tog;
        stog = !stog;
        rd[7] = susp;
        rd[6] = susp ? 1'b1 : tog;
        rd[2] = stog;
      end
    end
  end
  // Drive only while selected and gated, else inverse of last value
  assign dq_o = (!ce_n_i && !oe_n_i && rst_n_i) ?
    (byte_n_i ? rd : {~rd[15:8], rd[7:0]}) : ~rd;
  assign rb_oe_n_o = !(busy > 0 || (ebusy > 0 && !susp));
endmodule // fws_flash_model
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the flash host
module testbench;
  logic CLK_SYS_I, RST_B_I, REQ_VALID_I, WIDE_I, UNPROTECT_I, FLASH_RESET_I;
  logic REQ_READY_O, RSP_VALID_O, ERASE_SUSPENDED_O, ERASE_LOST_O, FL_CE_N_O;
  logic FL_OE_N_O, FL_WE_N_O, FL_BYTE_N_O, FL_WP_N_O, FL_RST_N_O, FL_DQ_OE_N_O;
  logic FL_READY_BUSY_N_I, rb_oe_n;
  logic [2:0] REQ_OP_I;
  logic [1:0] RSP_RES_O, res;
  logic [fws_pkg::ADDR_W-1:0] REQ_ADDR_I, FL_ADDR_O;
  logic [fws_pkg::DATA_W-1:0] REQ_DATA_I, RSP_DATA_O, FL_DQ_O, FL_DQ_I, m_dq, dat;
  logic [15:0] ref_mem[int];
  logic [15:0] lfsr = 16'h1275;
  logic [20:0] aq[$];
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  // Shared data bus; ready line wired straight to the model's pull-down enable
  assign FL_DQ_I = FL_DQ_OE_N_O ? m_dq : FL_DQ_O;
  assign FL_READY_BUSY_N_I = rb_oe_n;
  fws_host u_fws_host (.*);
  fws_flash_model u_fws_flash_model (.clk_i(CLK_SYS_I), .ce_n_i(FL_CE_N_O),
    .oe_n_i(FL_OE_N_O), .we_n_i(FL_WE_N_O), .byte_n_i(FL_BYTE_N_O), .wp_n_i(FL_WP_N_O),
    .rst_n_i(FL_RST_N_O), .addr_i(FL_ADDR_O), .dq_i(FL_DQ_I), .dq_o(m_dq), .rb_oe_n_o(rb_oe_n));
  // Clock source
  initial begin
    CLK_SYS_I = 0;
    forever #25 CLK_SYS_I = ~CLK_SYS_I;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] rf(input int a);
    return ref_mem.exists(a) ? ref_mem[a] : 16'hFFFF;
  endfunction
  task automatic chk_d(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One user request, held until taken
  task automatic put(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    REQ_OP_I = o;
    REQ_ADDR_I = a;
    REQ_DATA_I = d;
    REQ_VALID_I = 1;
    while (REQ_READY_O !== 1'b1 && n < 2000) begin
      @(posedge CLK_SYS_I);
      #1 n++;
    end
    @(posedge CLK_SYS_I);
    #1 REQ_VALID_I = 0;
  endtask
  // One user request, then its answer
  task automatic op(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    put(o, a, d);
    while (RSP_VALID_O !== 1'b1 && n < 20000) begin
      @(posedge CLK_SYS_I);
      #1 n++;
    end
    chk_b("answer", 2'h1, {1'b0, RSP_VALID_O});
    res = RSP_RES_O;
    dat = RSP_DATA_O;
    @(posedge CLK_SYS_I);
    #1;
  endtask
  task automatic pg(input logic [20:0] a, input logic [15:0] d);
    op(3'h1, a, d);
    chk_b("program result", 2'h0, res);
    if (UNPROTECT_I || a >= 21'h002000) ref_mem[a] = rf(a) & d;
  endtask
  task automatic wipe_ref(input logic [20:0] a, input int msk);
    foreach (ref_mem[k]) begin
      if ((k & msk) == (a & msk) && (UNPROTECT_I || k >= 21'h002000)) ref_mem[k] = 16'hFFFF;
    end
  endtask
  task automatic er(input logic [2:0] o, input logic [20:0] a, input int msk);
    op(o, a, 16'h0000);
    chk_b("erase result", 2'h0, res);
    wipe_ref(a, msk);
  endtask
  task automatic rc(input logic [20:0] a, input logic [15:0] e);
    op(3'h0, a, 16'h0000);
    chk_d("read data", e, dat);
  endtask
  // Cycle ceiling against hangs
  always @(posedge CLK_SYS_I) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  // Main sequence
  initial begin
    RST_B_I = 0;
    REQ_VALID_I = 0;
    REQ_OP_I = 3'h0;
    REQ_ADDR_I = 21'h000000;
    REQ_DATA_I = 16'h0000;
    WIDE_I = 1;
    UNPROTECT_I = 1;
    FLASH_RESET_I = 0;
    repeat (4) @(posedge CLK_SYS_I);
    #1 RST_B_I = 1;
    // Random programs in every bank, then read back
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      aq.push_back({i[2:0], lfsr[9:0], 8'h3C});
      pg(aq[i], lfsr);
    end
    foreach (aq[i]) rc(aq[i], rf(aq[i]));
    er(3'h2, aq[1], 21'h1FF800);
    rc(aq[1], 16'hFFFF);
    rc(aq[2], rf(aq[2]));
    $display("test program and sector erase done");
    // Protected region kept while the protect pin is low
    pg(21'h000010, 16'h1280);
    pg(21'h003000, 16'h5A5A);
    UNPROTECT_I = 0;
    pg(21'h000010, 16'h0280);
    er(3'h3, 21'h000000, 21'h1F8000);
    rc(21'h000010, 16'h1280);
    rc(21'h003000, 16'hFFFF);
    WIDE_I = 0;
    rc(21'h000010, 16'h0080);
    WIDE_I = 1;
    UNPROTECT_I = 1;
    $display("test protection and width done");
    // Suspend a running erase, one refused erase, program elsewhere, resume
    put(3'h2, aq[3], 16'h0000);
    wipe_ref(aq[3], 21'h1FF800);
    @(posedge CLK_SYS_I);
    #1 op(3'h5, aq[3], 16'h0000);
    chk_b("suspended", 2'h1, {1'b0, ERASE_SUSPENDED_O});
    chk_b("suspend result", 2'h0, res);
    op(3'h2, aq[3], 16'h0000);
    chk_b("refused erase", 2'h2, res);
    pg(aq[4] ^ 21'h000100, 16'h1234);
    op(3'h7, aq[4], 16'h0000);
    chk_b("id entry", 2'h0, res);
    op(3'h6, aq[3], 16'h0000);
    chk_b("resumed", 2'h0, {1'b0, ERASE_SUSPENDED_O});
    chk_b("resume result", 2'h0, res);
    rc(aq[3], rf(aq[3]));
    put(3'h3, aq[5], 16'h0000);
    wipe_ref(aq[5], 21'h1F8000);
    @(posedge CLK_SYS_I);
    #1 op(3'h5, aq[5], 16'h0000);
    FLASH_RESET_I = 1;
    @(posedge CLK_SYS_I);
    #1 FLASH_RESET_I = 0;
    repeat (20) @(posedge CLK_SYS_I);
    #1 chk_b("erase lost", 2'h1, {1'b0, ERASE_LOST_O});
    $display("test suspend and reset done");
    // Chip erase clears all
    er(3'h4, 21'h000000, 0);
    foreach (ref_mem[k]) rc(k[20:0], ref_mem[k]);
    $display("test chip erase done");
    results();
  end
endmodule // testbench
`default_nettype wire
